// [verilog/pbw_regs.svh]
/*
  Constants of the power button and wake input block: reset values,
  qualification counts and the standby clock rate.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef PBW_REGS_SVH
`define PBW_REGS_SVH

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PBW_MODE_ONE_RST 1'b1
`define PBW_GATE_N_RST 1'b1
`define PBW_LEVEL_RST 1'b1

// ----------------------------------------
// Timing
// ----------------------------------------
`define PBW_SLOW_CLK_HZ 32768
`define PBW_OFF_HOLD_S 4
`define PBW_QUAL_TICKS 4'h2
`define PBW_FILTER_TICKS 4'h8
`define PBW_TICK_W 4

`endif

// [verilog/pbw_pkg.sv]
/*
  Types shared by the power button and wake input block.
  Assumes pbw_regs.svh is on the include path.
*/
`include "pbw_regs.svh"

package pbw_pkg;

  // ----------------------------------------
  // Event group toward the power controller
  // ----------------------------------------
  typedef struct packed {
    logic power_on;
    logic power_off;
    logic skip;
    logic wake;
    logic sleep_req;
  } pbw_event_t;

  typedef logic [`PBW_TICK_W-1:0] pbw_ticks_t;

endpackage : pbw_pkg

// [verilog/pbw_input_qual.sv]
/*
  Pin synchroniser and slow-clock stable-level qualifier.
  Assumes an asynchronous pin and a one-cycle standby clock tick.
*/
`include "pbw_regs.svh"

module pbw_input_qual (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Pin and qualification
  input wire logic i_pin_n,
  input wire logic i_slow_tick,
  input wire pbw_pkg::pbw_ticks_t i_need_ticks,
  // Qualified level
  output logic o_level_q,
  output logic o_fall_q
);
  import pbw_pkg::*;

  logic meta_q;
  logic sync_q;
  pbw_ticks_t cnt_q;
  pbw_ticks_t cnt_inc;
  wire differs = sync_q != o_level_q;
  wire reached = differs && i_slow_tick && (cnt_inc >= i_need_ticks);

  assign cnt_inc = cnt_q + 1'b1;

  // Only sync_q reads the first stage
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q <= `PBW_LEVEL_RST;
      sync_q <= `PBW_LEVEL_RST;
    end else begin
      meta_q <= i_pin_n;
      sync_q <= meta_q;
    end
  end

  // Glitch restarts the count, so slow edges settle safely
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin // see R14
    if (!i_reset_n) begin
      cnt_q <= '0;
      o_level_q <= `PBW_LEVEL_RST;
      o_fall_q <= 1'b0;
    end else begin
      o_fall_q <= reached && !sync_q;
      if (!differs || reached) begin
        cnt_q <= '0;
      end else if (i_slow_tick) begin
        cnt_q <= cnt_inc;
      end
      if (reached) begin
        o_level_q <= sync_q;
      end
    end
  end

  a_level_needs_ticks: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // see R14
    (o_level_q != $past(o_level_q)) |->
      ($past(i_slow_tick) && ($past(cnt_q) + 1'b1 >= $past(i_need_ticks)))
  ) else $error("Level changed before enough standby clock edges");

endmodule : pbw_input_qual

// [verilog/pbw_power_inputs.sv]
/*
  Power button, wake event, sleep button and sleep clock gate handling.
  Assumes a free-running 10 MHz system clock, an asynchronous standby clock
  pin, and a power controller that consumes one-cycle event pulses.
*/
`include "pbw_regs.svh"

// How it works
// R1 - A qualified button push powers on, and holding it four seconds requests power off.
// R2 - The button pin is in auxiliary input mode one from reset without software help.
// R3 - The outside world holds each button level for two standby clock edges.
// R4 - Software enables the filter when glitches or slow edges may reach the button.
// R5 - The first push after power-up is taken once the input stays low two edges.
// R6 - After the first push the button is ignored until software enables it.
// R7 - A button held low with both powers present powers on at once.
// R8 - A low button when standby power appears is taken as a skip request.
// R9 - A low on the mapped wake input wakes the device from Sleep.
// R10 - The sleep clock gate is low in Sleep and high otherwise.
// R11 - The sleep clock gate is high from reset.
// R12 - A mapped sleep button push raises a sleep request event.
// R13 - Software turns off the button function before leaving mode one.
// R14 - Inputs are synchronised and their stable low is counted in standby clock edges.

module pbw_power_inputs #(
  parameter int HOLD_TICKS = `PBW_OFF_HOLD_S * `PBW_SLOW_CLK_HZ,
  parameter int HOLD_W = 18
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Pins
  input wire logic i_standby_slow_clock_in,
  input wire logic i_power_button_n,
  input wire logic i_wake_event_n,
  input wire logic i_sleep_button_n,
  // Software controls
  input wire logic i_mode_one_clr,
  input wire logic i_mode_one_set,
  input wire logic i_button_enable,
  input wire logic i_filter_enable,
  input wire logic i_wake_map_en,
  input wire logic i_sleep_button_map_en,
  // Power state
  input wire logic i_working_power_good,
  input wire logic i_system_on,
  input wire logic i_sleep_state,
  // Outputs
  output pbw_pkg::pbw_event_t o_events,
  output logic o_aux_input_mode_one,
  output logic o_sleep_clock_gate_n
);
  import pbw_pkg::*;

  // ----------------------------------------
  // Standby clock tick
  // ----------------------------------------
  logic sclk_meta_q;
  logic sclk_sync_q;
  logic sclk_prev_q;
  wire slow_tick = sclk_sync_q && !sclk_prev_q;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sclk_meta_q <= 1'b0;
      sclk_sync_q <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_meta_q <= i_standby_slow_clock_in;
      sclk_sync_q <= sclk_meta_q;
      sclk_prev_q <= sclk_sync_q;
    end
  end

  // ----------------------------------------
  // Input qualification
  // ----------------------------------------
  logic [2:0] pin_n;
  logic [2:0] level;
  logic [2:0] fall;
  pbw_ticks_t need;

  assign pin_n = {i_sleep_button_n, i_wake_event_n, i_power_button_n};
  assign need = i_filter_enable ? `PBW_FILTER_TICKS : `PBW_QUAL_TICKS; // see R14

  for (genvar g = 0; g < 3; g++) begin : g_qual
    pbw_input_qual u_qual (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_pin_n(pin_n[g]),
      .i_slow_tick(slow_tick),
      .i_need_ticks(need),
      .o_level_q(level[g]),
      .o_fall_q(fall[g])
    );
  end

  // ----------------------------------------
  // Button routing and state
  // ----------------------------------------
  logic mode_one_q;
  logic first_done_q;
  logic skip_pending_q;
  logic off_sent_q;
  pbw_ticks_t skip_wait_q;
  logic [HOLD_W-1:0] hold_q;
  pbw_event_t events_d;
  pbw_event_t events_q;

  wire btn_low = mode_one_q && !level[0];
  wire btn_fall = mode_one_q && fall[0];
  // Before software takes over only the first push counts
  wire btn_live = i_button_enable || !first_done_q; // see R5, R6
  wire push_on = btn_fall && btn_live && !i_system_on && !skip_pending_q; // see R1
  wire skip_hit = skip_pending_q && i_working_power_good && btn_low; // see R7, R8
  // High must outlast one full qualification, else the reset value decides
  wire skip_tick = skip_pending_q && i_working_power_good && level[0] && slow_tick;
  wire skip_clear = skip_tick && (skip_wait_q >= need); // see R8
  wire hold_done = hold_q == HOLD_W'(HOLD_TICKS - 1);
  wire off_hit = btn_low && i_button_enable && i_system_on && !off_sent_q &&
    slow_tick && hold_done; // see R1

  always_comb begin
    events_d.power_on = push_on || skip_hit;
    events_d.skip = skip_hit;
    events_d.power_off = off_hit;
    events_d.wake = fall[1] && i_wake_map_en && i_sleep_state; // see R9
    events_d.sleep_req = fall[2] && i_sleep_button_map_en; // see R12
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_one_q <= `PBW_MODE_ONE_RST; // see R2
    end else if (i_mode_one_set) begin
      mode_one_q <= 1'b1;
    end else if (i_mode_one_clr) begin
      mode_one_q <= 1'b0;
    end
  end

  // Skip decision waits for a qualified level, not the raw strap
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      skip_pending_q <= 1'b1;
      skip_wait_q <= '0;
      first_done_q <= 1'b0;
    end else begin
      if (skip_tick) begin
        skip_wait_q <= skip_wait_q + 1'b1;
      end
      if (skip_hit || skip_clear) begin
        skip_pending_q <= 1'b0; // see R8
      end
      if (push_on || skip_hit) begin
        first_done_q <= 1'b1; // see R6
      end
    end
  end

  // Hold counter in standby ticks; one power-off per hold
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hold_q <= '0;
      off_sent_q <= 1'b0;
    end else if (!btn_low) begin
      hold_q <= '0;
      off_sent_q <= 1'b0;
    end else if (slow_tick && !hold_done) begin
      hold_q <= hold_q + 1'b1; // see R1
    end else if (off_hit) begin
      off_sent_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      events_q <= '0;
      o_sleep_clock_gate_n <= `PBW_GATE_N_RST; // see R11
    end else begin
      events_q <= events_d;
      o_sleep_clock_gate_n <= !i_sleep_state; // see R10
    end
  end

  assign o_events = events_q;
  assign o_aux_input_mode_one = mode_one_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_first_push;
    !first_done_q && btn_fall && !i_system_on && !skip_pending_q;
  endsequence

  sequence s_on_then_done;
    o_events.power_on ##1 first_done_q;
  endsequence

  a_first_push_on: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // see R5
    s_first_push |=> s_on_then_done
  ) else $error("First qualified push did not power on");

  a_ignore_until_enable: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // see R6
    (first_done_q && !i_button_enable && !skip_pending_q) |=> !o_events.power_on
  ) else $error("Button acted before software enabled it");

  a_skip_immediate: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // see R7
    skip_hit |=> (o_events.skip && o_events.power_on) ##1 !skip_pending_q
  ) else $error("Skip did not power on at once");

  a_skip_needs_low: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // see R8
    o_events.skip |-> $past(skip_pending_q) && !$past(level[0])
  ) else $error("Skip raised without a low button");

  a_off_after_hold: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // see R1
    o_events.power_off |-> $past(btn_low) && ($past(hold_q) == HOLD_W'(HOLD_TICKS - 1))
  ) else $error("Power off without the full hold");

  a_mode_one_clear: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // see R2
    (i_mode_one_clr && !i_mode_one_set) |=> !o_aux_input_mode_one ##1
      (o_aux_input_mode_one == $past(i_mode_one_set))
  ) else $error("Mode one did not follow software");

  a_wake_in_sleep: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // see R9
    o_events.wake |-> $past(i_sleep_state) && $past(i_wake_map_en) && $past(fall[1])
  ) else $error("Wake outside Sleep or unmapped");

  a_gate_in_sleep: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // see R10
    $rose(i_sleep_state) |=> !o_sleep_clock_gate_n ##1 (o_sleep_clock_gate_n == !$past(i_sleep_state))
  ) else $error("Clock gate not low in Sleep");

  a_gate_awake: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // see R10
    (!i_sleep_state) [*2] |-> o_sleep_clock_gate_n
  ) else $error("Clock gate low while awake");

  a_sleep_button: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // see R12
    (fall[2] && i_sleep_button_map_en) |=> o_events.sleep_req ##1 !o_events.sleep_req
  ) else $error("Sleep button push lost");

endmodule : pbw_power_inputs

// [bench/pbw_far_side_model.sv]
/*
  Far side model: standby crystal, power button, wake and sleep buttons.
  Assumes the bench calls drive() and press() from its main sequence.
*/
module pbw_far_side_model (
  // Clock
  input wire logic i_clk_sys,
  // Pins: 0 button, 1 wake, 2 sleep button
  output logic o_slow_clk,
  output logic [2:0] o_pins_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Crystal and pins
  // ----------------------------------------
  // Crystal runs free, frames or not
  initial o_slow_clk = 1'b0;
  always #15259 o_slow_clk = ~o_slow_clk;
  // Pull-ups hold idle pins high
  initial o_pins_n = 3'h7;

  task automatic drive(input int pin, input logic v);
    @(posedge i_clk_sys) #10 o_pins_n[pin] = v;
  endtask : drive

  // Short glitches only on the first push, where no filter is needed
  task automatic press(input int pin, input int ticks, input bit glitch);
    int i;
    for (i = 0; i < 3 && glitch; i++) begin
      drive(pin, 1'b0);
      drive(pin, 1'b1);
    end
    drive(pin, 1'b0);
    repeat (ticks) @(posedge o_slow_clk);
    drive(pin, 1'b1);
    repeat (3) @(posedge o_slow_clk);
    // Return on the bench's drive slot, not on a crystal edge
    @(posedge i_clk_sys) #10;
  endtask : press
endmodule : pbw_far_side_model

// [bench/test_power_button_wake_inputs.sv]
/*
  Self-checking bench of the power button and wake input block.
  Assumes the design package and the far side model are compiled first.
*/
module test_power_button_wake_inputs;
  timeunit 1ns;
  timeprecision 1ns;
  import pbw_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int ON = 4, OFF = 3, SKIP = 2, WAKE = 1, SREQ = 0;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic mode_clr = 1'b0, mode_set = 1'b0, btn_en = 1'b0, filt_en = 1'b0;
  logic wake_map = 1'b0, sleep_map = 1'b0, wpg = 1'b1, sys_on = 1'b0, in_sleep = 1'b0;
  logic slow_clk, aux_mode, gate_n;
  logic [2:0] pins_n;
  pbw_event_t events;
  int cnt [5];
  int err_count = 0;
  int compares = 0;

  always #50 clk_sys = ~clk_sys;

  pbw_far_side_model fs (.i_clk_sys(clk_sys), .o_slow_clk(slow_clk), .o_pins_n(pins_n));

  // Short hold count keeps the off test brief
  pbw_power_inputs #(.HOLD_TICKS(4), .HOLD_W(18)) uut (
    .i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_standby_slow_clock_in(slow_clk),
    .i_power_button_n(pins_n[0]), .i_wake_event_n(pins_n[1]), .i_sleep_button_n(pins_n[2]),
    .i_mode_one_clr(mode_clr), .i_mode_one_set(mode_set), .i_button_enable(btn_en),
    .i_filter_enable(filt_en), .i_wake_map_en(wake_map), .i_sleep_button_map_en(sleep_map),
    .i_working_power_good(wpg), .i_system_on(sys_on), .i_sleep_state(in_sleep),
    .o_events(events), .o_aux_input_mode_one(aux_mode), .o_sleep_clock_gate_n(gate_n));

  // One-cycle pulses are counted where they stand
  always @(posedge clk_sys) begin
    for (int k = 0; k < 5; k++) begin
      if (events[k] === 1'b1) cnt[k]++;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  task automatic chk_bit(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : chk_bit

  task automatic chk_cnt(input int k, input int exp, input string what);
    compares++;
    if (cnt[k] != exp) begin
      err_count++;
      $display("wrong value at %0t: %s count %0d", $time, what, cnt[k]);
    end
  endtask : chk_cnt

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask : step
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset(input logic btn);
    fs.drive(0, btn);
    reset_n = 1'b0;
    wpg = btn;
    step(16);
    chk_bit(aux_mode, 1'b1, "mode one in reset");
    chk_bit(gate_n, 1'b1, "gate in reset");
    chk_bit(|events, 1'b0, "events in reset");
    cnt = '{default: 0};
    reset_n = 1'b1;
    repeat (5) @(posedge slow_clk);
    step(1);
    chk_cnt(SKIP, 0, "skip before working power");
    wpg = 1'b1;
    repeat (5) @(posedge slow_clk);
    step(1);
    chk_cnt(SKIP, btn ? 0 : 1, "skip");
    fs.drive(0, 1'b1);
    repeat (3) @(posedge slow_clk);
  endtask : t_reset

  task automatic t_pushes;
    cnt = '{default: 0};
    fs.press(0, 3, 1'b1);
    chk_cnt(ON, 1, "first push");
    fs.press(0, 3, 1'b0);
    chk_cnt(ON, 1, "push before enable");
    btn_en = 1'b1;
    fs.press(0, 3, 1'b0);
    chk_cnt(ON, 2, "enabled push");
    sys_on = 1'b1;
    fs.press(0, 8, 1'b0);
    chk_cnt(OFF, 1, "hold off");
    chk_cnt(ON, 2, "push while on");
    sys_on = 1'b0;
    filt_en = 1'b1;
    fs.press(0, 4, 1'b0);
    chk_cnt(ON, 2, "filtered short push");
    fs.press(0, 11, 1'b0);
    chk_cnt(ON, 3, "filtered long push");
    filt_en = 1'b0;
  endtask : t_pushes

  task automatic t_wake_sleep;
    cnt = '{default: 0};
    in_sleep = 1'b1;
    step(2);
    chk_bit(gate_n, 1'b0, "gate in sleep");
    wake_map = 1'b1;
    fs.press(1, 3, 1'b0);
    chk_cnt(WAKE, 1, "mapped wake");
    wake_map = 1'b0;
    fs.press(1, 3, 1'b0);
    chk_cnt(WAKE, 1, "unmapped wake");
    in_sleep = 1'b0;
    step(2);
    chk_bit(gate_n, 1'b1, "gate awake");
    sleep_map = 1'b1;
    fs.press(2, 3, 1'b0);
    chk_cnt(SREQ, 1, "sleep button");
  endtask : t_wake_sleep

  task automatic t_mode_one;
    cnt = '{default: 0};
    btn_en = 1'b0;
    step(1);
    mode_clr = 1'b1;
    step(1);
    mode_clr = 1'b0;
    step(1);
    chk_bit(aux_mode, 1'b0, "mode one cleared");
    btn_en = 1'b1;
    fs.press(0, 3, 1'b0);
    chk_cnt(ON, 0, "push outside mode one");
    mode_set = 1'b1;
    step(1);
    mode_set = 1'b0;
    step(1);
    chk_bit(aux_mode, 1'b1, "mode one set");
  endtask : t_mode_one
  // ----------------------------------------
  // Run
  // ----------------------------------------
  task automatic print_verdict;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    t_reset(1'b1);
    t_pushes();
    t_wake_sleep();
    t_mode_one();
    t_reset(1'b0);
    print_verdict();
  end

  // About 1.6 times the expected run
  initial begin
    #5000000;
    err_count++;
    print_verdict();
  end
endmodule : test_power_button_wake_inputs
